// ==== rtl/isf_pkg.sv ====
package isf_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS        = 10;
    localparam int REC_HOLD_US          = 165;
    localparam int REC_HOLD_MAX_US      = 270;
    localparam int REC_HOLD_CYCLES      = (REC_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEGLITCH_FALL_NS     = 5700;
    localparam int DEGLITCH_FALL_CYCLES = (DEGLITCH_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RISE_SLOPE_X100      = 355;
    localparam int RISE_OFFSET_NS       = 153;
    localparam int RISE_MIN_NS          = 235;
    localparam int SAMPLE_PERIOD_NS     = 1000;
    localparam int SAMPLE_CYCLES        = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRETCH_CYCLES       = 2 * SAMPLE_CYCLES;

    localparam int CNT_W  = 20;
    localparam int SYNC_W = 3;
    typedef logic [CNT_W-1:0] isf_cnt_t;

    // register offsets
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_RESPONSE_SELECT_PIN   = 12'h004;
    localparam logic [11:0] OFS_REF    = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;

    // field positions and reset values
    localparam int          CTRL_LATCHED_BIT = 0;
    localparam logic        CTRL_LATCHED_RST = 1'b0;
    localparam logic [9:0]  RESPONSE_SELECT_PIN_KOHM_RST    = 10'h064;
    localparam logic [7:0]  REF_CODE_RST     = 8'h80;
    localparam logic [31:0] RDATA_RST        = 32'h0000_0000;

    typedef enum logic {
        MODE_STANDBY,
        MODE_ACTIVE
    } isf_mode_e;

    typedef struct packed {
        logic lvl;
        isf_cnt_t cnt;
    } isf_filt_s;

    typedef struct packed {
        logic      alarm_flag;
        logic      fault_flag;
        logic      fault_latched;
        logic      recovering;
        logic      alarm_filt;
        logic      fault_filt;
        logic      gate;
        isf_mode_e mode;
    } isf_status_s;

endpackage : isf_pkg

// ==== rtl/isf_top.sv ====
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - chip enable high with supply present: active mode, power transfer on.
// - chip enable low with supply present: standby, no transfer, gate low.
// - gate drive follows the received switch-enable level.
// - raw fault comparator high when fault sense exceeds reference.
// - deglitch comparator; rising time from resistor, falling time fixed.
// - filtered fault rise forces gate low at once, whatever enable says.
// - each fault starts a recovery timer holding gate low.
// - non-latched: after fault clears, gate low until timer expires, then follows enable.
// - new fault while timer runs restarts the timer.
// - each transfer interval, status sampled and sent back to update flags.
// - fault-assert events stretched for the sampler; recovery events not stretched.
// - received fault event pulls the open-drain fault flag low.
// - non-latched: sampled recovery releases fault flag, gate waits for timer.
// - latched: gate low until enable went low and timer expired.
// - latched: fault flag low until host drives enable low.
// - latched: once recovered and cleared, flag releases even with timer running.
// - alarm sense above reference pulls alarm flag low, gate untouched.
// - recovery hold lasts typically 165 us, at most 270 us.
// - rising deglitch ns is max of 3.55 times kilo-ohms plus 153, and 235.
// - latched: timer keeps running while latched, gate low until it expires.
module isf_top #(
    parameter int REC_CYCLES = isf_pkg::REC_HOLD_CYCLES
) (
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_B,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // host pins, asynchronous
    input  wire logic        CHIP_ENABLE_IN,
    input  wire logic        PRIMARY_SUPPLY,
    input  wire logic        SWITCH_ENABLE_IN,
    // converter codes, same clock
    input  wire logic [7:0]  FAULT_SENSE_IN,
    input  wire logic [7:0]  ALARM_SENSE_IN,
    // outputs
    output logic             GATE_DRIVE_OUT,
    output logic             POWER_TRANSFER_OUT,
    output logic             FAULT_FLAG_N_O,
    output logic             FAULT_FLAG_N_OE,
    output logic             ALARM_FLAG_N_O,
    output logic             ALARM_FLAG_N_OE
);

    // rising filter length in cycles, rounded up, never below the floor
    function automatic isf_pkg::isf_cnt_t rise_cycles(input logic [9:0] kohm);
        int ns_x100;
        int cyc;
        ns_x100 = isf_pkg::RISE_SLOPE_X100 * int'(kohm) + isf_pkg::RISE_OFFSET_NS * 100;
        if (ns_x100 < isf_pkg::RISE_MIN_NS * 100) begin
            ns_x100 = isf_pkg::RISE_MIN_NS * 100;
        end
        cyc = (ns_x100 + isf_pkg::CLK_PERIOD_NS * 100 - 1) / (isf_pkg::CLK_PERIOD_NS * 100);
        return isf_pkg::isf_cnt_t'(cyc);
    endfunction : rise_cycles

    // one filter step; a bounce back to the held level restarts the count
    function automatic isf_pkg::isf_filt_s filt_step(input isf_pkg::isf_filt_s cur,
                                                     input logic                raw,
                                                     input isf_pkg::isf_cnt_t   rise_lim);
        isf_pkg::isf_filt_s nxt;
        isf_pkg::isf_cnt_t  lim;
        nxt = cur;
        lim = raw ? rise_lim : isf_pkg::isf_cnt_t'(isf_pkg::DEGLITCH_FALL_CYCLES);
        if (raw == cur.lvl) begin
            nxt.cnt = '0;
        end else if (cur.cnt + isf_pkg::isf_cnt_t'(1) >= lim) begin
            nxt.lvl = raw;
            nxt.cnt = '0;
        end else begin
            nxt.cnt = cur.cnt + isf_pkg::isf_cnt_t'(1);
        end
        return nxt;
    endfunction : filt_step

    // pin synchronisers: en, ce, supply
    logic [isf_pkg::SYNC_W-1:0] en_sync_r, ce_sync_r, sup_sync_r;
    logic [isf_pkg::SYNC_W-1:0] en_sync_nxt, ce_sync_nxt, sup_sync_nxt;
    logic                       en_r, ce_r, sup_r;
    logic                       en_nxt, ce_nxt, sup_nxt;

    always_comb begin
        en_sync_nxt  = {en_sync_r[1:0], SWITCH_ENABLE_IN};
        ce_sync_nxt  = {ce_sync_r[1:0], CHIP_ENABLE_IN};
        sup_sync_nxt = {sup_sync_r[1:0], PRIMARY_SUPPLY};
        en_nxt       = (en_sync_r[1] == en_sync_r[2]) ? en_sync_r[2] : en_r;
        ce_nxt       = (ce_sync_r[1] == ce_sync_r[2]) ? ce_sync_r[2] : ce_r;
        sup_nxt      = (sup_sync_r[1] == sup_sync_r[2]) ? sup_sync_r[2] : sup_r;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            en_sync_r  <= '0;
            ce_sync_r  <= '0;
            sup_sync_r <= '0;
            en_r       <= 1'b0;
            ce_r       <= 1'b0;
            sup_r      <= 1'b0;
        end else begin
            en_sync_r  <= en_sync_nxt;
            ce_sync_r  <= ce_sync_nxt;
            sup_sync_r <= sup_sync_nxt;
            en_r       <= en_nxt;
            ce_r       <= ce_nxt;
            sup_r      <= sup_nxt;
        end
    end

    // registers and apb
    logic                latched_r, latched_nxt;
    logic [9:0]          response_select_pin_r, response_select_pin_nxt;
    logic [7:0]          ref_r, ref_nxt;
    logic [31:0]         prdata_r, prdata_nxt;
    logic                pready_r, pready_nxt;
    logic                pslverr_r, pslverr_nxt;
    isf_pkg::isf_status_s status;
    logic                acc, hit;

    // core state
    isf_pkg::isf_filt_s  ffilt_r, ffilt_nxt, afilt_r, afilt_nxt;
    isf_pkg::isf_cnt_t   rec_r, rec_nxt, fstr_r, fstr_nxt, astr_r, astr_nxt;
    isf_pkg::isf_cnt_t   smp_r, smp_nxt;
    logic                flatch_r, flatch_nxt;
    logic                fbc_r, fbc_nxt, abc_r, abc_nxt;
    logic                gate_r, gate_nxt, pwr_r, pwr_nxt;
    logic                fflag_r, fflag_nxt, aflag_r, aflag_nxt;
    logic                active, frise, arise, tick;

    always_comb begin
        status               = '0;
        status.mode          = pwr_r ? isf_pkg::MODE_ACTIVE : isf_pkg::MODE_STANDBY;
        status.gate          = gate_r;
        status.fault_filt    = ffilt_r.lvl;
        status.alarm_filt    = afilt_r.lvl;
        status.recovering    = (rec_r != '0);
        status.fault_latched = flatch_r;
        status.fault_flag    = fflag_r;
        status.alarm_flag    = aflag_r;
        acc                  = PSEL && PENABLE && !pready_r;
        latched_nxt          = latched_r;
        response_select_pin_nxt             = response_select_pin_r;
        ref_nxt              = ref_r;
        prdata_nxt           = prdata_r;
        pready_nxt           = acc;
        pslverr_nxt          = 1'b0;
        hit                  = 1'b1;
        if (acc) begin
            prdata_nxt = isf_pkg::RDATA_RST;
            if (PADDR == isf_pkg::OFS_CTRL) begin
                prdata_nxt[isf_pkg::CTRL_LATCHED_BIT] = latched_r;
            end else if (PADDR == isf_pkg::OFS_RESPONSE_SELECT_PIN) begin
                prdata_nxt[9:0] = response_select_pin_r;
            end else if (PADDR == isf_pkg::OFS_REF) begin
                prdata_nxt[7:0] = ref_r;
            end else if (PADDR == isf_pkg::OFS_STATUS) begin
                prdata_nxt[7:0] = status;
            end else begin
                hit = 1'b0;
            end
            pslverr_nxt = !hit;
        end
        // writes land at the edge that samples pready high
        if (PSEL && PENABLE && pready_r && PWRITE && !pslverr_r) begin
            if (PADDR == isf_pkg::OFS_CTRL) begin
                latched_nxt = PWDATA[isf_pkg::CTRL_LATCHED_BIT];
            end else if (PADDR == isf_pkg::OFS_RESPONSE_SELECT_PIN) begin
                response_select_pin_nxt = PWDATA[9:0];
            end else if (PADDR == isf_pkg::OFS_REF) begin
                ref_nxt = PWDATA[7:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            latched_r <= isf_pkg::CTRL_LATCHED_RST;
            response_select_pin_r    <= isf_pkg::RESPONSE_SELECT_PIN_KOHM_RST;
            ref_r     <= isf_pkg::REF_CODE_RST;
            prdata_r  <= isf_pkg::RDATA_RST;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            latched_r <= latched_nxt;
            response_select_pin_r    <= response_select_pin_nxt;
            ref_r     <= ref_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    always_comb begin
        active    = ce_r && sup_r;
        pwr_nxt   = active;
        ffilt_nxt = filt_step(ffilt_r, FAULT_SENSE_IN > ref_r, rise_cycles(response_select_pin_r));
        afilt_nxt = filt_step(afilt_r, ALARM_SENSE_IN > ref_r, rise_cycles(response_select_pin_r));
        frise     = ffilt_nxt.lvl && !ffilt_r.lvl;
        arise     = afilt_nxt.lvl && !afilt_r.lvl;
        // recovery timer reloads while fault stands, counts down after it clears
        if (ffilt_r.lvl) begin
            rec_nxt = isf_pkg::isf_cnt_t'(REC_CYCLES);
        end else if (rec_r != '0) begin
            rec_nxt = rec_r - isf_pkg::isf_cnt_t'(1);
        end else begin
            rec_nxt = rec_r;
        end
        // latch: set wins over clear by low enable once recovered
        if (latched_r && frise) begin
            flatch_nxt = 1'b1;
        end else if (!en_r && !ffilt_r.lvl) begin
            flatch_nxt = 1'b0;
        end else begin
            flatch_nxt = flatch_r;
        end
        gate_nxt = active && en_r && !ffilt_nxt.lvl && !ffilt_r.lvl
                   && (rec_r == '0) && !flatch_nxt;
        // assert events stretched, recovery events not
        fstr_nxt = frise ? isf_pkg::isf_cnt_t'(isf_pkg::STRETCH_CYCLES) :
                   (fstr_r != '0) ? fstr_r - isf_pkg::isf_cnt_t'(1) : fstr_r;
        astr_nxt = arise ? isf_pkg::isf_cnt_t'(isf_pkg::STRETCH_CYCLES) :
                   (astr_r != '0) ? astr_r - isf_pkg::isf_cnt_t'(1) : astr_r;
        // back-channel sampler runs only during power transfer
        tick    = active && (smp_r == isf_pkg::isf_cnt_t'(isf_pkg::SAMPLE_CYCLES - 1));
        smp_nxt = !active ? '0 : tick ? '0 : smp_r + isf_pkg::isf_cnt_t'(1);
        fbc_nxt = tick ? (ffilt_r.lvl || fstr_r != '0) : fbc_r;
        abc_nxt = tick ? (afilt_r.lvl || astr_r != '0) : abc_r;
        // flags move only on a tick or, for the fault flag, when the latch changes; standby keeps the last sampled state
        fflag_nxt = fbc_nxt || (latched_r && flatch_nxt);
        aflag_nxt = abc_nxt;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            ffilt_r  <= '0;
            afilt_r  <= '0;
            rec_r    <= '0;
            fstr_r   <= '0;
            astr_r   <= '0;
            smp_r    <= '0;
            flatch_r <= 1'b0;
            fbc_r    <= 1'b0;
            abc_r    <= 1'b0;
            gate_r   <= 1'b0;
            pwr_r    <= 1'b0;
            fflag_r  <= 1'b0;
            aflag_r  <= 1'b0;
        end else begin
            ffilt_r  <= ffilt_nxt;
            afilt_r  <= afilt_nxt;
            rec_r    <= rec_nxt;
            fstr_r   <= fstr_nxt;
            astr_r   <= astr_nxt;
            smp_r    <= smp_nxt;
            flatch_r <= flatch_nxt;
            fbc_r    <= fbc_nxt;
            abc_r    <= abc_nxt;
            gate_r   <= gate_nxt;
            pwr_r    <= pwr_nxt;
            fflag_r  <= fflag_nxt;
            aflag_r  <= aflag_nxt;
        end
    end

    // open-drain pins: level held at zero, enable drives low
    logic od_low_r, od_low_nxt;
    always_comb begin
        od_low_nxt = 1'b0;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            od_low_r <= 1'b0;
        end else begin
            od_low_r <= od_low_nxt;
        end
    end

    assign PRDATA             = prdata_r;
    assign PREADY             = pready_r;
    assign PSLVERR            = pslverr_r;
    assign GATE_DRIVE_OUT     = gate_r;
    assign POWER_TRANSFER_OUT = pwr_r;
    assign FAULT_FLAG_N_O     = od_low_r;
    assign FAULT_FLAG_N_OE    = fflag_r;
    assign ALARM_FLAG_N_O     = od_low_r;
    assign ALARM_FLAG_N_OE    = aflag_r;

endmodule : isf_top

`default_nettype wire

// ==== testbench/isf_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module isf_asserts #(
    parameter int REC_CYCLES = 300
) (
    // clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST_B,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // pins
    input wire logic [7:0]  FAULT_SENSE_IN,
    input wire logic [7:0]  ALARM_SENSE_IN,
    input wire logic        GATE_DRIVE_OUT,
    input wire logic        POWER_TRANSFER_OUT,
    input wire logic        FAULT_FLAG_N_O,
    input wire logic        FAULT_FLAG_N_OE,
    input wire logic        ALARM_FLAG_N_O,
    input wire logic        ALARM_FLAG_N_OE
);
    logic        wr;
    logic [7:0]  ref_r, ref_nxt;
    logic [9:0]  response_select_pin_r, response_select_pin_nxt;
    logic [15:0] fhi_r, fhi_nxt, ahi_r, ahi_nxt, flo_r, flo_nxt;
    logic        trip_r, trip_nxt;
    int          rise;
    always_comb begin
        wr = PSEL && PENABLE && PREADY && PWRITE;
        ref_nxt = (wr && PADDR == isf_pkg::OFS_REF) ? PWDATA[7:0] : ref_r;
        response_select_pin_nxt = (wr && PADDR == isf_pkg::OFS_RESPONSE_SELECT_PIN) ? PWDATA[9:0] : response_select_pin_r;
        rise = (355 * int'(response_select_pin_r) / 100 + 153 + 9) / 10;
        if (rise < 24) rise = 24;
        fhi_nxt = (FAULT_SENSE_IN > ref_r) ? fhi_r + 16'(fhi_r != 16'hffff) : 16'h0000;
        ahi_nxt = (ALARM_SENSE_IN > ref_r) ? ahi_r + 16'(ahi_r != 16'hffff) : 16'h0000;
        flo_nxt = (FAULT_SENSE_IN > ref_r) ? 16'h0000 : flo_r + 16'(flo_r != 16'hffff);
        trip_nxt = trip_r || (fhi_r >= 16'(rise));
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            ref_r <= isf_pkg::REF_CODE_RST;
            response_select_pin_r <= isf_pkg::RESPONSE_SELECT_PIN_KOHM_RST;
            fhi_r <= 16'h0000;
            ahi_r <= 16'h0000;
            flo_r <= 16'h0000;
            trip_r <= 1'b0;
        end else begin
            ref_r <= ref_nxt;
            response_select_pin_r <= response_select_pin_nxt;
            fhi_r <= fhi_nxt;
            ahi_r <= ahi_nxt;
            flo_r <= flo_nxt;
            trip_r <= trip_nxt;
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    sequence acc_s; PSEL && PENABLE && !PREADY; endsequence
    sequence done_s; PREADY ##1 !PREADY; endsequence
    apb_answer_a: assert property (acc_s |=> done_s) else $error("apb answer late");
    apb_err_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
    od_level_a: assert property (!FAULT_FLAG_N_O && !ALARM_FLAG_N_O)
        else $error("open-drain level high");
    standby_gate_a: assert property (!POWER_TRANSFER_OUT [*2] |-> !GATE_DRIVE_OUT)
        else $error("gate on in standby");
    fault_trip_a: assert property (fhi_r > 16'(rise + 3) |-> !GATE_DRIVE_OUT)
        else $error("gate on during fault");
    fault_flag_a: assert property (fhi_r > 16'(rise + 120) && POWER_TRANSFER_OUT
        |-> FAULT_FLAG_N_OE) else $error("fault flag missing");
    alarm_flag_a: assert property (ahi_r > 16'(rise + 120) && POWER_TRANSFER_OUT
        |-> ALARM_FLAG_N_OE) else $error("alarm flag missing");
    gate_hold_a: assert property ($rose(GATE_DRIVE_OUT) && trip_r
        |-> flo_r >= 16'(isf_pkg::DEGLITCH_FALL_CYCLES + REC_CYCLES - 2))
        else $error("gate back too early");
    flag_gate_a: assert property (FAULT_FLAG_N_OE |-> !GATE_DRIVE_OUT)
        else $error("gate on with fault flag");
endmodule : isf_asserts
bind isf_top isf_asserts #(.REC_CYCLES(REC_CYCLES)) u_asserts (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FAULT_SENSE_IN(FAULT_SENSE_IN), .ALARM_SENSE_IN(ALARM_SENSE_IN),
    .GATE_DRIVE_OUT(GATE_DRIVE_OUT), .POWER_TRANSFER_OUT(POWER_TRANSFER_OUT),
    .FAULT_FLAG_N_O(FAULT_FLAG_N_O), .FAULT_FLAG_N_OE(FAULT_FLAG_N_OE),
    .ALARM_FLAG_N_O(ALARM_FLAG_N_O), .ALARM_FLAG_N_OE(ALARM_FLAG_N_OE));
`default_nettype wire

// ==== testbench/isf_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module isf_host_model (
    // clock
    input  wire logic core_clk,
    // enables toward the device
    output logic      chip_enable,
    output logic      supply_on,
    output logic      switch_enable,
    // open-drain flags, pulled up
    input  wire logic fault_oe,
    input  wire logic alarm_oe,
    output logic      fault_flag_n,
    output logic      alarm_flag_n
);
    assign fault_flag_n = !fault_oe;
    assign alarm_flag_n = !alarm_oe;
    initial begin
        chip_enable = 1'b0;
        supply_on = 1'b0;
        switch_enable = 1'b0;
    end
    task automatic set_pins(input logic ce, input logic sup, input logic en);
        @(posedge core_clk);
        chip_enable <= ce;
        supply_on <= sup;
        switch_enable <= en;
    endtask : set_pins
    // enable low longer than one sample period
    task automatic clear_fault();
        set_pins(1'b1, 1'b1, 1'b0);
        repeat (120) @(posedge core_clk);
        set_pins(1'b1, 1'b1, 1'b1);
    endtask : clear_fault
endmodule : isf_host_model
`default_nettype wire

// ==== testbench/isolated_switch_fault_control_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module isolated_switch_fault_control_tb_top;
    localparam int REC = 300;
    localparam int FALL = isf_pkg::DEGLITCH_FALL_CYCLES;
    logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic ce, sup, en, gate, xfer, f_o, f_oe, a_o, a_oe, f_n, a_n;
    logic [7:0] fs, as, rf;
    int seed = 32'h4246_58bb;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    isf_top #(.REC_CYCLES(REC)) u_dut (.CORE_CLK(core_clk), .RST_B(rst_b), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CHIP_ENABLE_IN(ce), .PRIMARY_SUPPLY(sup),
        .SWITCH_ENABLE_IN(en), .FAULT_SENSE_IN(fs), .ALARM_SENSE_IN(as), .GATE_DRIVE_OUT(gate),
        .POWER_TRANSFER_OUT(xfer), .FAULT_FLAG_N_O(f_o), .FAULT_FLAG_N_OE(f_oe),
        .ALARM_FLAG_N_O(a_o), .ALARM_FLAG_N_OE(a_oe));
    isf_host_model u_host (.core_clk(core_clk), .chip_enable(ce), .supply_on(sup),
        .switch_enable(en), .fault_oe(f_oe), .alarm_oe(a_oe), .fault_flag_n(f_n),
        .alarm_flag_n(a_n));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic finish_test();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // status word: b0 active, b1 gate, all else clear
    function automatic logic [31:0] stat_word(input logic act, input logic gt);
        return {30'h0000_0000, gt, act};
    endfunction : stat_word
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, exp);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic wait_gate(input logic lvl, input int lim);
        repeat (lim) if (gate !== lvl) @(posedge core_clk);
        chk(32'(gate), 32'(lvl));
    endtask : wait_gate
    task automatic sense(input logic alm, input int len);
        logic [7:0] v;
        v = rf + 8'h01 + 8'($random(seed) & 15);
        if (alm) as <= v;
        else fs <= v;
        repeat (len) @(posedge core_clk);
        fs <= rf;
        as <= rf;
    endtask : sense
    initial begin
        logic [31:0] q;
        logic e;
        {rst_b, psel, penable, pwrite, paddr, pwdata, fs, as, rf} = '0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(isf_pkg::OFS_CTRL, 32'h0000_0000);
        rd(isf_pkg::OFS_RESPONSE_SELECT_PIN, 32'h0000_0064);
        rd(isf_pkg::OFS_REF, 32'h0000_0080);
        wr(isf_pkg::OFS_STATUS, 32'hffff_ffff);
        rd(isf_pkg::OFS_STATUS, stat_word(1'b0, 1'b0));
        apb(1'b1, 12'h010, 32'hffff_ffff, q, e);
        chk(32'(e), 32'h0000_0001);
        rf = 8'h20 + 8'($random(seed) & 127);
        fs <= rf;
        as <= rf;
        wr(isf_pkg::OFS_REF, {24'hffff_ff, rf});
        rd(isf_pkg::OFS_REF, {24'h0000_00, rf});
        wr(isf_pkg::OFS_RESPONSE_SELECT_PIN, 32'h0000_0000);
        u_host.set_pins(1'b1, 1'b1, 1'b1);
        wait_gate(1'b1, 20);
        rd(isf_pkg::OFS_STATUS, stat_word(1'b1, 1'b1));
        repeat (2) begin
            sense(1'b0, 22);
            @(posedge core_clk);
        end
        chk(32'(gate), 32'h0000_0001);
        u_host.set_pins(1'b1, 1'b1, 1'b0);
        wait_gate(1'b0, 20);
        u_host.set_pins(1'b1, 1'b1, 1'b1);
        wait_gate(1'b1, 20);
        sense(1'b0, 150);
        chk(32'(gate), 32'h0000_0000);
        chk(32'(f_n), 32'h0000_0000);
        repeat (FALL + 106) @(posedge core_clk);
        chk(32'(f_n), 32'h0000_0001);
        chk(32'(gate), 32'h0000_0000);
        wait_gate(1'b1, REC);
        sense(1'b0, 40);
        repeat (FALL + 150) @(posedge core_clk);
        sense(1'b0, 40);
        repeat (FALL + REC - 20) @(posedge core_clk);
        chk(32'(gate), 32'h0000_0000);
        wait_gate(1'b1, 60);
        wr(isf_pkg::OFS_CTRL, 32'h0000_0001);
        sense(1'b0, 40);
        repeat (FALL + REC + 50) @(posedge core_clk);
        chk(32'(gate), 32'h0000_0000);
        chk(32'(f_n), 32'h0000_0000);
        u_host.clear_fault();
        wait_gate(1'b1, 30);
        sense(1'b0, 40);
        repeat (FALL + 20) @(posedge core_clk);
        u_host.clear_fault();
        repeat (20) @(posedge core_clk);
        chk(32'(f_n), 32'h0000_0001);
        chk(32'(gate), 32'h0000_0000);
        wait_gate(1'b1, REC);
        wr(isf_pkg::OFS_CTRL, 32'h0000_0000);
        sense(1'b1, 150);
        chk(32'(a_n), 32'h0000_0000);
        chk(32'(gate), 32'h0000_0001);
        repeat (FALL + 106) @(posedge core_clk);
        chk(32'(a_n), 32'h0000_0001);
        for (int i = 0; i < 2; i++) begin
            u_host.set_pins(1'(i), 1'(i == 0), 1'b1);
            repeat (8) @(posedge core_clk);
            chk(32'(xfer), 32'h0000_0000);
            chk(32'(gate), 32'h0000_0000);
            chk(32'({f_o, a_o}), 32'h0000_0000);
            u_host.set_pins(1'b1, 1'b1, 1'b1);
            wait_gate(1'b1, 20);
        end
        finish_test();
    end
endmodule : isolated_switch_fault_control_tb_top
`default_nettype wire
